// *** hbg_consts.svh ***
// Timing constants and sizes for the half-bridge gate command controller
// Overview of operation
// - Hold every command level over 500 ns
// - Hold fault clear high over 500 ns
// - Hold fault line low over 500 ns
// - Start-up: supply, check line, charge, drop
`ifndef HBG_CONSTS_SVH
`define HBG_CONSTS_SVH

// ****************************************************************
// Clock and pulse timing
// ****************************************************************
`define HBG_CLK_MHZ         100
`define HBG_MIN_PULSE_NS    500
// Strictly longer than the minimum pulse width, so one cycle extra
`define HBG_MIN_PULSE_CYC   ((`HBG_MIN_PULSE_NS * `HBG_CLK_MHZ) / 1000 + 1)
`define HBG_HOLD_W          8
`define HBG_HOLD_MAX        8'hFF

// ****************************************************************
// Start-up bootstrap charge time
// ****************************************************************
`define HBG_CHARGE_US       10
`define HBG_CHARGE_CYC      (`HBG_CHARGE_US * `HBG_CLK_MHZ)
`define HBG_CHARGE_W        12

// ****************************************************************
// Pin bookkeeping
// ****************************************************************
`define HBG_SYNC_W          2
`define HBG_OE_HIST_W       3
`define HBG_NUM_PINS        4

`endif

// *** hbg_pkg.sv ***
// Types shared by the half-bridge gate command controller
package hbg_pkg;

    // Start-up and run sequence
    typedef enum logic [2:0] {
        HBG_ST_WAIT_SUPPLY,
        HBG_ST_CHECK_LINE,
        HBG_ST_CHARGE,
        HBG_ST_DROP,
        HBG_ST_RUN
    } hbg_state_e;

    // Hold counter
    typedef logic [7:0] hbg_hold_t;

endpackage

// *** hbg_min_hold.sv ***
// Level holder that keeps each output level for a minimum number of cycles
`timescale 1ns/1ps
`include "hbg_consts.svh"

module hbg_min_hold (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_req,
    output logic      o_level
);

    // ****************************************************************
    // Hold counter
    // ****************************************************************
    hbg_pkg::hbg_hold_t cnt_r;      // Cycles since last output change
    logic               level_r;    // Output level
    wire                hold_done;  // Minimum hold time served
    wire                want_flip;  // Request differs from output and hold time served

    assign hold_done = (cnt_r >= hbg_pkg::hbg_hold_t'(`HBG_MIN_PULSE_CYC - 1));
    assign want_flip = (i_req != level_r) && hold_done;
    assign o_level   = level_r;

    // Change only once the present level has stood long enough
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            level_r <= 1'b0;
            cnt_r   <= `HBG_HOLD_MAX;
        end else if (want_flip) begin
            level_r <= i_req;
            cnt_r   <= 8'h00;
        end else if (!hold_done) begin
            cnt_r   <= cnt_r + 8'h01;
        end
    end

endmodule

// *** hbg_host_ctrl.sv ***
// Controller that drives the half-bridge gate driver command and fault pins
`timescale 1ns/1ps
`include "hbg_consts.svh"

module hbg_host_ctrl (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_start,             // Begin start-up sequence
    input  wire logic i_hs_req,            // Wanted high-side state
    input  wire logic i_ls_req,            // Wanted low-side state
    input  wire logic i_fault_clear_req,   // One-cycle request to clear a fault
    input  wire logic i_fault_force,       // Level: pull shared fault line low
    input  wire logic i_supply_good,       // Low-side supply present (pin)
    input  wire logic i_fault_line_in,     // Shared fault line level (pin)
    output logic      o_high_side_command,
    output logic      o_low_side_command,
    output logic      o_fault_clear_input,
    output logic      o_fault_line_out,
    output logic      o_fault_line_oe,
    output logic      o_fault_seen,
    output logic      o_running
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`HBG_SYNC_W-1:0] supply_sync_r;  // Supply good, two stages
    logic [`HBG_SYNC_W-1:0] line_sync_r;    // Fault line, two stages
    wire                    supply_ok;      // Synchronised supply good
    wire                    line_high;      // Synchronised fault line

    // Two flops each; only the second stage is read by logic
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            supply_sync_r <= 2'h0;
            line_sync_r   <= 2'h3;
        end else begin
            supply_sync_r <= {supply_sync_r[0], i_supply_good};
            line_sync_r   <= {line_sync_r[0], i_fault_line_in};
        end
    end

    assign supply_ok = supply_sync_r[1];
    assign line_high = line_sync_r[1];

    // ****************************************************************
    // Sequence state and wanted gate states
    // ****************************************************************
    hbg_pkg::hbg_state_e       state_r;       // Sequence state
    hbg_pkg::hbg_state_e       state_nxt;
    logic [`HBG_CHARGE_W-1:0]  charge_cnt_r;  // Bootstrap charge cycles
    logic                      hs_want_r;     // Held high-side wish
    logic                      ls_want_r;     // Held low-side wish
    logic                      clr_pend_r;    // Fault clear awaiting pulse
    logic [`HBG_OE_HIST_W-1:0] oe_hist_r;     // Recent own drive of line
    logic                      fault_seen_r;  // Line low from elsewhere
    logic                      running_r;     // Sequence in run state
    logic                      line_out_r;    // Level driven when enabled
    logic                      hs_cmd;        // Holder outputs
    logic                      ls_cmd;
    logic                      clr_cmd;
    logic                      oe_cmd;
    wire                       run;           // In run state
    wire                       both_req;      // Both sides requested
    wire                       charge_done;   // Charge time served
    wire                       hs_in;         // Holder requests
    wire                       ls_in;
    wire                       clr_pend_nxt;
    wire                       ext_fault;     // Line low, not by us

    assign run         = (state_r == hbg_pkg::HBG_ST_RUN);
    assign both_req    = i_hs_req && i_ls_req;
    assign charge_done = (charge_cnt_r == `HBG_CHARGE_W'(`HBG_CHARGE_CYC - 1));
    assign ext_fault   = !line_high && !oe_cmd && (oe_hist_r == 3'h0);

    // Never ask for both switches; stop on a line fault not driven by us
    assign hs_in = run && hs_want_r && !fault_seen_r && !ls_cmd;
    // Charge phase drives low side alone
    assign ls_in = ((state_r == hbg_pkg::HBG_ST_CHARGE) && !hs_cmd) ||
                   (run && ls_want_r && !fault_seen_r && !hs_cmd);

    // A new request wins over the clearing of the pending flag
    assign clr_pend_nxt = i_fault_clear_req || (clr_pend_r && !clr_cmd);

    // Start-up sequence: supply, check line, charge, drop
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hbg_pkg::HBG_ST_WAIT_SUPPLY: begin
                if (i_start && supply_ok) begin
                    state_nxt = hbg_pkg::HBG_ST_CHECK_LINE;
                end
            end
            hbg_pkg::HBG_ST_CHECK_LINE: begin
                if (line_high && !hs_cmd) begin
                    state_nxt = hbg_pkg::HBG_ST_CHARGE;
                end
            end
            hbg_pkg::HBG_ST_CHARGE: begin
                if (charge_done) begin
                    state_nxt = hbg_pkg::HBG_ST_DROP;
                end
            end
            hbg_pkg::HBG_ST_DROP: begin
                if (!ls_cmd) begin
                    state_nxt = hbg_pkg::HBG_ST_RUN;
                end
            end
            hbg_pkg::HBG_ST_RUN: begin
                if (!supply_ok) begin
                    state_nxt = hbg_pkg::HBG_ST_WAIT_SUPPLY;
                end
            end
            default: begin
                state_nxt = hbg_pkg::HBG_ST_WAIT_SUPPLY;
            end
        endcase
    end

    // Sequence state register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= hbg_pkg::HBG_ST_WAIT_SUPPLY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Charge timer counts only while the low command is really high
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            charge_cnt_r <= 12'h000;
        end else if (state_r == hbg_pkg::HBG_ST_CHARGE && ls_cmd && !charge_done) begin
            charge_cnt_r <= charge_cnt_r + 12'h001;
        end else if (state_r != hbg_pkg::HBG_ST_CHARGE) begin
            charge_cnt_r <= 12'h000;
        end
    end

    // Wishes keep their last value when both sides are asked for
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hs_want_r <= 1'b0;
            ls_want_r <= 1'b0;
        end else if (!both_req) begin
            hs_want_r <= i_hs_req;
            ls_want_r <= i_ls_req;
        end
    end

    // Fault status, own drive history and run flag
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            clr_pend_r   <= 1'b0;
            oe_hist_r    <= 3'h0;
            fault_seen_r <= 1'b0;
            running_r    <= 1'b0;
            line_out_r   <= 1'b0;
        end else begin
            clr_pend_r   <= clr_pend_nxt;
            oe_hist_r    <= {oe_hist_r[1:0], oe_cmd};
            fault_seen_r <= ext_fault;
            running_r    <= run;
            line_out_r   <= 1'b0;
        end
    end

    // ****************************************************************
    // Minimum-width holders for each driven pin
    // ****************************************************************
    hbg_min_hold u_hold_hs (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_req      (hs_in),
        .o_level    (hs_cmd)
    );

    hbg_min_hold u_hold_ls (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_req      (ls_in),
        .o_level    (ls_cmd)
    );

    // Clear pulse rises on a pending request and falls after the hold
    hbg_min_hold u_hold_clr (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_req      (clr_pend_r),
        .o_level    (clr_cmd)
    );

    // Pull of the shared line, held low at least the minimum width
    hbg_min_hold u_hold_oe (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_req      (i_fault_force),
        .o_level    (oe_cmd)
    );

    assign o_high_side_command = hs_cmd;
    assign o_low_side_command  = ls_cmd;
    assign o_fault_clear_input = clr_cmd;
    assign o_fault_line_oe     = oe_cmd;
    assign o_fault_line_out    = line_out_r;
    assign o_fault_seen        = fault_seen_r;
    assign o_running           = running_r;

    // ****************************************************************
    // Assertions and cover points
    // ****************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    wire [`HBG_NUM_PINS-1:0] pins_now = {oe_cmd, clr_cmd, ls_cmd, hs_cmd};
    logic [`HBG_NUM_PINS-1:0] pins_prev_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_prev_r <= 4'h0;
        end else begin
            pins_prev_r <= pins_now;
        end
    end

    // Age of each pin level, checked at every change
    for (genvar g = 0; g < `HBG_NUM_PINS; g++) begin : g_age
        hbg_pkg::hbg_hold_t age_r;
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                age_r <= `HBG_HOLD_MAX;
            end else if (pins_now[g] != pins_prev_r[g]) begin
                age_r <= 8'h01;
            end else if (age_r != `HBG_HOLD_MAX) begin
                age_r <= age_r + 8'h01;
            end
        end
        a_pin_min_width: assert property (
            (pins_now[g] != pins_prev_r[g]) |-> (age_r >= hbg_pkg::hbg_hold_t'(`HBG_MIN_PULSE_CYC)))
            else $error("pin level shorter than minimum width");
    end

    a_charge_low_only: assert property (
        (state_r == hbg_pkg::HBG_ST_CHARGE) |-> !hs_cmd)
        else $error("high command during bootstrap charge");

    a_no_cmd_before_supply: assert property (
        (state_r == hbg_pkg::HBG_ST_CHECK_LINE) |-> $past(supply_ok) && !ls_cmd)
        else $error("sequence left supply wait without supply");

    a_charge_before_run: assert property (
        $rose(run) |-> $past(state_r) == hbg_pkg::HBG_ST_DROP && !ls_cmd)
        else $error("run entered without drop of low command");

    a_clear_pulse_bounded: assert property (
        $rose(clr_pend_r) |-> ##[1:60] clr_cmd)
        else $error("fault clear pulse did not start in time");

    a_no_both_high: assert property (
        !(hs_cmd && ls_cmd))
        else $error("both gate commands high");

    c_reach_run:     cover property ($rose(run));
    c_clear_pulse:   cover property ($fell(clr_cmd));
    c_force_line:    cover property ($fell(oe_cmd));
    c_external_flt:  cover property ($rose(fault_seen_r) && run);

endmodule

// *** hbg_drv_model.sv ***
// Behavioural model of the gate driver on the far side of the controller
`timescale 1ns/1ps

module hbg_drv_model #(
    parameter int FILT = 20,  // Input filter, 200 ns
    parameter int UVT  = 800, // Undervoltage filter, 8 us
    parameter int CLMP = 40   // Clamp filter, 400 ns
) (
    input  wire logic i_core_clk,
    input  wire logic i_vcc_ok,             // Low side supply above power reset
    input  wire logic i_high_side_command,
    input  wire logic i_low_side_command,
    input  wire logic i_fault_clear_input,
    input  wire logic i_shared_fault_line,
    input  wire logic i_overcurrent_sense,
    input  wire logic i_floating_supply_ok,
    output logic      o_high_gate_output,
    output logic      o_low_gate_output,
    output logic      o_fault_line_oe,
    output logic [1:0] o_clamp_on          // Clamp transistors on, high side in bit 0
);
    // ****************************************
    // Filtered inputs and state
    // ****************************************
    logic [3:0] raw;       // Line, clear, low, high
    logic [3:0] flt_r;     // Filtered levels
    logic [3:0] prv_r;     // Filtered levels one cycle back
    int         cnt_r [4]; // Cycles each input has differed
    int         uv_r;      // Undervoltage persistence
    logic       fault_r;   // Overcurrent fault latch
    logic       lock_r;    // High side locked out
    logic       h_rise;    // Filtered high command edge
    logic [1:0] clamp_r;   // Clamp transistor on, high side in bit 0
    int         exc_r [2]; // Cycles each gate has stood high
    wire  [1:0] gate = {o_low_gate_output, o_high_gate_output};
    assign raw = {i_shared_fault_line, i_fault_clear_input, i_low_side_command, i_high_side_command};
    assign h_rise = flt_r[0] & ~prv_r[0];
    assign o_fault_line_oe = fault_r;
    assign o_clamp_on = clamp_r;

    // A level passes only after FILT steady cycles
    always_ff @(posedge i_core_clk or negedge i_vcc_ok) begin
        if (!i_vcc_ok) begin
            flt_r <= 4'h8;
            prv_r <= 4'h8;
            cnt_r <= '{default: 0};
        end else begin
            prv_r <= flt_r;
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= (raw[i] == flt_r[i]) ? 0 : cnt_r[i] + 1;
                if (cnt_r[i] == FILT) flt_r[i] <= raw[i];
            end
        end
    end

    // Fault latch, high side lockout and gate outputs
    always_ff @(posedge i_core_clk or negedge i_vcc_ok) begin
        if (!i_vcc_ok) begin
            fault_r <= 1'h0;
            lock_r <= 1'h0;
            uv_r <= 0;
            o_high_gate_output <= 1'h0;
            o_low_gate_output <= 1'h0;
        end else begin
            uv_r <= i_floating_supply_ok ? 0 : uv_r + 1;
            if (flt_r[2]) fault_r <= 1'h0;
            else if (i_overcurrent_sense && flt_r[1]) fault_r <= 1'h1;
            if (uv_r >= UVT) lock_r <= 1'h1;
            else if (h_rise) lock_r <= 1'h0;
            if (fault_r || !flt_r[3]) begin
                o_high_gate_output <= 1'h0;
                o_low_gate_output <= 1'h0;
            end else if (flt_r[1:0] == 2'h3) begin
                if (prv_r[1:0] == 2'h0) begin
                    o_high_gate_output <= 1'h1;
                    o_low_gate_output <= 1'h0;
                end
            end else begin
                o_low_gate_output <= flt_r[1];
                if (flt_r[0] != prv_r[0] || prv_r[1:0] == 2'h3) o_high_gate_output <= flt_r[0];
            end
            if (uv_r >= UVT || (lock_r && !h_rise)) o_high_gate_output <= 1'h0;
        end
    end

    // Clamp holds a low gate low; a short excursion of the gate keeps it on
    always_ff @(posedge i_core_clk or negedge i_vcc_ok) begin
        if (!i_vcc_ok) begin
            clamp_r <= 2'h0;
            exc_r   <= '{default: 0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                exc_r[i] <= gate[i] ? exc_r[i] + 1 : 0;
                if (!flt_r[i] && !gate[i]) clamp_r[i] <= 1'h1;
                else if (flt_r[i] || exc_r[i] >= CLMP) clamp_r[i] <= 1'h0;
            end
        end
    end
endmodule

// *** hbg_host_ctrl_tb_top.sv ***
// Self-checking bench for the half-bridge gate command controller
`timescale 1ns/1ps

module hbg_host_ctrl_tb_top;
    logic        clk     = 1'h0;   // Core clock
    logic        rst     = 1'h1;   // Reset
    logic        start   = 1'h0;   // Start-up request
    logic        hs_req  = 1'h0;   // High side wish
    logic        ls_req  = 1'h0;   // Low side wish
    logic        clr_req = 1'h0;   // Fault clear request
    logic        frc     = 1'h0;   // Force fault line low
    logic        supply  = 1'h0;   // Low side supply present
    logic        oc      = 1'h0;   // Overcurrent sense
    logic        hs_cmd, ls_cmd, clr_pin, oe, line_out, seen, running, hgate, lgate, dev_oe;
    logic [1:0]  clamp;            // Driver clamp state, high side in bit 0
    wire         line = ~(oe | dev_oe);  // Pulled-up open-drain fault line
    wire  [3:0]  mon = {oe, clr_pin, ls_cmd, hs_cmd};
    logic [3:0]  mon_q;            // Watched pins last cycle
    int          len [4];          // Cycles each watched pin has stood
    int          miscompares = 0;
    int          cmp_count   = 0;
    int          n;
    logic [31:0] seed = 32'h07A5;  // Random state
    logic [1:0]  wish = 2'h0;      // Expected commands, high then low

    always #5 clk = ~clk;

    hbg_host_ctrl dut (.i_core_clk(clk), .i_rst(rst), .i_start(start), .i_hs_req(hs_req), .i_ls_req(ls_req),
        .i_fault_clear_req(clr_req), .i_fault_force(frc), .i_supply_good(supply), .i_fault_line_in(line),
        .o_high_side_command(hs_cmd), .o_low_side_command(ls_cmd), .o_fault_clear_input(clr_pin),
        .o_fault_line_out(line_out), .o_fault_line_oe(oe), .o_fault_seen(seen), .o_running(running));

    hbg_drv_model dev (.i_core_clk(clk), .i_vcc_ok(supply), .i_high_side_command(hs_cmd),
        .i_low_side_command(ls_cmd), .i_fault_clear_input(clr_pin), .i_shared_fault_line(line),
        .i_overcurrent_sense(oc), .i_floating_supply_ok(1'h1), .o_high_gate_output(hgate),
        .o_low_gate_output(lgate), .o_fault_line_oe(dev_oe), .o_clamp_on(clamp));

    // Next random state
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Both wishes high keeps the previous pair
    function automatic logic [1:0] want(input logic [1:0] prev, input logic h, input logic l);
        return (h && l) ? prev : {h, l};
    endfunction

    task automatic chk_bit(input logic exp, input logic act);
        cmp_count++;
        if (exp !== act) begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, act);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // New wishes, then time for holders and filters
    task automatic set_req(input logic h, input logic l);
        @(posedge clk);
        hs_req <= h;
        ls_req <= l;
        tick(150);
    endtask

    // Pulse the one-cycle inputs
    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 0) oc <= 1'h1;
        else if (which == 1) clr_req <= 1'h1;
        else frc <= 1'h1;
        @(posedge clk);
        oc <= 1'h0;
        clr_req <= 1'h0;
        frc <= 1'h0;
        tick(40);
        @(negedge clk);
    endtask

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Every level on the watched pins must stand long enough
    always @(negedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                len[i] <= 60;
            end else if (mon[i] !== mon_q[i]) begin
                chk_bit(1'h1, len[i] >= 51);
                if (i == 2 && mon_q[i]) chk_bit(1'h1, len[i] == 51);
                len[i] <= 1;
            end else begin
                len[i] <= len[i] + 1;
            end
        end
        mon_q <= mon;
        if (!rst) chk_bit(1'h0, hs_cmd & ls_cmd);
    end

    // Hang guard
    initial begin
        #150000;
        miscompares++;
        complete_run();
    end

    initial begin
        tick(20);
        rst <= 1'h0;
        start <= 1'h1;
        tick(50);
        @(negedge clk);
        chk_bit(1'h0, ls_cmd);
        chk_bit(1'h0, line_out);
        @(posedge clk);
        supply <= 1'h1;
        n = 0;
        while (ls_cmd !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_bit(1'h0, hs_cmd);
        n = 0;
        while (ls_cmd === 1'h1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        chk_bit(1'h1, n >= 1000 && n <= 1003);
        tick(5);
        @(negedge clk);
        chk_bit(1'h1, running);
        chk_bit(1'h1, line);
        $display("test startup done");
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            @(posedge clk);
            hs_req <= seed[0];
            ls_req <= seed[1];
            wish = want(wish, seed[0], seed[1]);
            tick(seed[7:4] * 8);
        end
        tick(200);
        @(negedge clk);
        chk_bit(wish[1], hs_cmd);
        chk_bit(wish[0], ls_cmd);
        chk_bit(wish[1], hgate);
        chk_bit(wish[0], lgate);
        $display("test random commands done");
        set_req(1'h1, 1'h0);
        pulse(0);
        chk_bit(1'h0, seen);
        chk_bit(1'h1, hgate);
        set_req(1'h0, 1'h1);
        pulse(0);
        chk_bit(1'h1, seen);
        chk_bit(1'h0, line);
        chk_bit(1'h0, lgate);
        tick(100);
        @(negedge clk);
        chk_bit(1'h0, ls_cmd);
        pulse(1);
        tick(80);
        @(negedge clk);
        chk_bit(1'h1, line);
        chk_bit(1'h0, seen);
        tick(150);
        @(negedge clk);
        chk_bit(1'h1, lgate);
        $display("test overcurrent done");
        set_req(1'h1, 1'h0);
        pulse(2);
        chk_bit(1'h0, line);
        chk_bit(1'h0, hgate);
        tick(60);
        @(negedge clk);
        chk_bit(1'h1, line);
        chk_bit(1'h0, hgate);
        set_req(1'h0, 1'h0);
        set_req(1'h1, 1'h0);
        @(negedge clk);
        chk_bit(1'h1, hgate);
        chk_bit(1'h0, clamp[0]);
        chk_bit(1'h1, clamp[1]);
        $display("test forced fault done");
        // Supply loss drops the sequence and resets the driver
        @(posedge clk);
        supply <= 1'h0;
        tick(10);
        @(negedge clk);
        chk_bit(1'h0, running);
        chk_bit(1'h0, hgate);
        chk_bit(1'h1, line);
        $display("test supply loss done");
        complete_run();
    end
endmodule
